// ==== src/fifo_pkg.sv ====
// constants, offsets and state codes for the fifo reset and mailbox block
// assumes one 40 MHz clock; port clocks and pins arrive asynchronously
//
// Behaviour
// - reset pin is asynchronous, synchronised inside
// - reset clears pointers and forces four status flags
// - reset forces both mail flags high
// - write space rises four port a edges after release
// - edge counts only with reset low around it
// - mail flags set and cleared on opposite port edges
// - a-to-b mail shows on port b at once
// - b-to-a mail shows on port a at once
// - each bus driven only in its read direction
// - fifo write qualified by port a controls
// - fifo read qualified by port b controls
// - status flags pass two stages in their port domain
package fifo_pkg;
    localparam int BUS_W = 36;
    localparam int DEPTH_LOG2 = 9;
    localparam int OFS_W = 16;
    localparam int IRQ_W = 4;
    localparam logic [2:0] RESET_EDGES = 3'h4;
    localparam logic [1:0] IR_EDGES = 2'h2;
    localparam logic [OFS_W-1:0] OFS_RESET = 16'h0008;
    localparam logic [7:0] STATUS_ADDR = 8'h00;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h04;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h08;
    localparam logic [7:0] NEAR_EMPTY_OFS_ADDR = 8'h0c;
    localparam logic [7:0] NEAR_FULL_OFS_ADDR = 8'h10;
    localparam logic [7:0] LEVEL_ADDR = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int EV_A_MAIL = 0;
    localparam int EV_B_MAIL = 1;
    localparam int EV_RST_DONE = 2;
    localparam int EV_RST_SHORT = 3;
    typedef enum logic [2:0] {
        ST_UNINIT = 3'b001,
        ST_RESET = 3'b010,
        ST_RUN = 3'b100
    } ctl_state_t;
endpackage : fifo_pkg

// ==== src/fifo_word_ram.sv ====
// word store for the fifo, one write port and a registered read port
// assumes the caller never reads an address in the cycle it is written
`timescale 1ns/1ps
`default_nettype none
module fifo_word_ram #(
    parameter int WIDTH = 36,
    parameter int AW = 9
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule : fifo_word_ram
`default_nettype wire

// ==== src/fifo_mailbox_ctrl.sv ====
// reset sequencing, flags, mailboxes and bus drive of the two-port fifo
// assumes port clocks far slower than aclk; every pin is synchronised
`timescale 1ns/1ps
`default_nettype none
module fifo_mailbox_ctrl #(
    parameter int DEPTH_LOG2 = fifo_pkg::DEPTH_LOG2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic irq,
    input wire logic fifo_reset_n,
    input wire logic port_a_clock,
    input wire logic port_a_select_n,
    input wire logic port_a_dir,
    input wire logic port_a_mail_sel,
    input wire logic port_a_strobe_en,
    input wire logic [fifo_pkg::BUS_W-1:0] port_a_bus_in,
    output logic [fifo_pkg::BUS_W-1:0] port_a_bus_out,
    output logic port_a_bus_oe,
    input wire logic port_b_clock,
    input wire logic port_b_select_n,
    input wire logic port_b_dir,
    input wire logic port_b_mail_sel,
    input wire logic port_b_xfer_en,
    input wire logic [fifo_pkg::BUS_W-1:0] port_b_bus_in,
    output logic [fifo_pkg::BUS_W-1:0] port_b_bus_out,
    output logic port_b_bus_oe,
    output logic write_space_flag,
    output logic read_valid_flag,
    output logic near_empty_flag,
    output logic near_full_flag,
    output logic a_to_b_mail_flag,
    output logic b_to_a_mail_flag
);
    import fifo_pkg::*;
    localparam int AW = DEPTH_LOG2;
    localparam logic [31:0] DEPTH32 = 32'(2**AW);

    // logic reads the second stage of each synchroniser, plus a third stage of the reset and the port clocks
    logic [4:0] a_s1, a_s2, b_s1, b_s2;
    logic [BUS_W-1:0] a_in_s1, a_in_s2, b_in_s1, b_in_s2;
    logic rst_s1, rst_s2, rst_s3, a_clk_s3, b_clk_s3;
    always_ff @(posedge aclk) begin
        a_s1 <= {port_a_clock, port_a_select_n, port_a_dir, port_a_mail_sel, port_a_strobe_en};
        b_s1 <= {port_b_clock, port_b_select_n, port_b_dir, port_b_mail_sel, port_b_xfer_en};
        a_in_s1 <= port_a_bus_in;
        b_in_s1 <= port_b_bus_in;
        rst_s1 <= fifo_reset_n;
        a_s2 <= a_s1;
        b_s2 <= b_s1;
        a_in_s2 <= a_in_s1;
        b_in_s2 <= b_in_s1;
        rst_s2 <= rst_s1;
        rst_s3 <= rst_s2;
        a_clk_s3 <= a_s2[4];
        b_clk_s3 <= b_s2[4];
    end

    logic a_edge, b_edge, in_rst;
    logic a_sel_n, a_dir, a_mbs, a_en, b_sel_n, b_dir, b_mbs, b_en;
    assign a_edge = a_s2[4] & ~a_clk_s3;
    assign b_edge = b_s2[4] & ~b_clk_s3;
    assign {a_sel_n, a_dir, a_mbs, a_en} = a_s2[3:0];
    assign {b_sel_n, b_dir, b_mbs, b_en} = b_s2[3:0];
    assign in_rst = ~rst_s2;

    // reset sequencing; uninit blocks all fifo and mail traffic until a full reset is seen
    ctl_state_t state;
    logic [2:0] a_rcnt, b_rcnt;
    logic [1:0] rel_cnt;
    logic rst_full, rst_end;
    assign rst_full = (a_rcnt == RESET_EDGES) && (b_rcnt == RESET_EDGES);
    assign rst_end = (state == ST_RESET) && !in_rst;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_UNINIT;
        end else begin
            case (state)
                ST_UNINIT: if (in_rst) state <= ST_RESET;
                ST_RESET: if (!in_rst) state <= rst_full ? ST_RUN : ST_UNINIT;
                ST_RUN: if (in_rst) state <= ST_RESET;
                default: state <= ST_UNINIT;
            endcase
        end
    end

    // an edge counts only when reset was already low the cycle before
    always_ff @(posedge aclk) begin
        if (!aresetn || state != ST_RESET) begin
            a_rcnt <= '0;
            b_rcnt <= '0;
        end else begin
            if (a_edge && in_rst && !rst_s3 && a_rcnt != RESET_EDGES) a_rcnt <= a_rcnt + 3'h1;
            if (b_edge && in_rst && !rst_s3 && b_rcnt != RESET_EDGES) b_rcnt <= b_rcnt + 3'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state != ST_RUN) begin
            rel_cnt <= '0;
        end else if (a_edge && rel_cnt != IR_EDGES) begin
            rel_cnt <= rel_cnt + 2'h1;
        end
    end

    // pointers and word count
    logic [AW:0] wr_ptr, rd_ptr, level;
    logic [31:0] lvl32;
    logic full, empty, fifo_wr, fifo_rd;
    logic [OFS_W-1:0] ne_ofs, nf_ofs;
    assign level = wr_ptr - rd_ptr;
    assign lvl32 = 32'(level);
    assign full = level[AW];
    assign empty = (level == '0);
    assign fifo_wr = state == ST_RUN && a_edge && !a_sel_n && !a_mbs && a_dir && a_en
                     && write_space_flag && !full;
    assign fifo_rd = state == ST_RUN && b_edge && !b_sel_n && !b_mbs && b_dir && b_en
                     && read_valid_flag && !empty;

    always_ff @(posedge aclk) begin
        if (!aresetn || state != ST_RUN) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (fifo_wr) wr_ptr <= wr_ptr + 1'b1;
            if (fifo_rd) rd_ptr <= rd_ptr + 1'b1;
        end
    end

    logic [BUS_W-1:0] ram_rdata, out_word;
    fifo_word_ram #(.WIDTH(BUS_W), .AW(AW)) u_ram (
        .clk(aclk),
        .we(fifo_wr),
        .waddr(wr_ptr[AW-1:0]),
        .wdata(a_in_s2),
        .raddr(rd_ptr[AW-1:0]),
        .rdata(ram_rdata)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_word <= '0;
        end else if (fifo_rd) begin
            out_word <= ram_rdata;
        end
    end

    // flags lag the count by two port edges; the full and empty guards cover the lag
    logic ws1, nf1, rv1, ne1;
    always_ff @(posedge aclk) begin
        if (!aresetn || state != ST_RUN) begin
            ws1 <= 1'b0;
            write_space_flag <= 1'b0;
            nf1 <= 1'b1;
            near_full_flag <= 1'b1;
        end else if (a_edge) begin
            ws1 <= (rel_cnt == IR_EDGES) && !full;
            write_space_flag <= ws1;
            nf1 <= (lvl32 + 32'(nf_ofs)) < DEPTH32;
            near_full_flag <= nf1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state != ST_RUN) begin
            rv1 <= 1'b0;
            read_valid_flag <= 1'b0;
            ne1 <= 1'b0;
            near_empty_flag <= 1'b0;
        end else if (b_edge) begin
            rv1 <= !empty;
            read_valid_flag <= rv1;
            ne1 <= lvl32 > 32'(ne_ofs);
            near_empty_flag <= ne1;
        end
    end

    // mailboxes: a new write beats a same-cycle read of the old mail
    logic a_mail_wr, a_mail_rd, b_mail_wr, b_mail_rd;
    logic [BUS_W-1:0] a_to_b_mailbox, b_to_a_mailbox;
    assign a_mail_wr = state == ST_RUN && a_edge && !a_sel_n && a_dir && a_mbs && a_en;
    assign a_mail_rd = state == ST_RUN && a_edge && !a_sel_n && !a_dir && a_mbs && a_en;
    assign b_mail_wr = state == ST_RUN && b_edge && !b_sel_n && !b_dir && b_mbs && b_en;
    assign b_mail_rd = state == ST_RUN && b_edge && !b_sel_n && b_dir && b_mbs && b_en;

    always_ff @(posedge aclk) begin
        if (!aresetn || state != ST_RUN) begin
            a_to_b_mail_flag <= 1'b1;
            b_to_a_mail_flag <= 1'b1;
        end else begin
            if (a_mail_wr) a_to_b_mail_flag <= 1'b0;
            else if (b_mail_rd) a_to_b_mail_flag <= 1'b1;
            if (b_mail_wr) b_to_a_mail_flag <= 1'b0;
            else if (a_mail_rd) b_to_a_mail_flag <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_to_b_mailbox <= '0;
            b_to_a_mailbox <= '0;
        end else begin
            if (a_mail_wr) a_to_b_mailbox <= a_in_s2;
            if (b_mail_wr) b_to_a_mailbox <= b_in_s2;
        end
    end

    // bus drive refreshed every aclk, so mail appears without a port edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_a_bus_oe <= 1'b0;
            port_a_bus_out <= '0;
            port_b_bus_oe <= 1'b0;
            port_b_bus_out <= '0;
        end else begin
            port_a_bus_oe <= !a_sel_n && !a_dir;
            port_a_bus_out <= a_mbs ? b_to_a_mailbox : '0;
            port_b_bus_oe <= !b_sel_n && b_dir;
            port_b_bus_out <= b_mbs ? a_to_b_mailbox : out_word;
        end
    end

    // interrupt status, write one to clear; a new event wins over the clear
    logic [IRQ_W-1:0] irq_status, irq_mask, events, w1c;
    assign events = {rst_end && !rst_full, rst_end && rst_full, b_mail_wr, a_mail_wr};

    // axi4-lite write side
    logic aw_full, w_full, do_wr, next_aw_full, next_w_full;
    logic [7:0] wr_addr;
    logic [31:0] wr_data, wmask;
    logic [3:0] wr_strb;
    assign do_wr = aw_full && w_full && !bvalid;
    assign next_aw_full = do_wr ? 1'b0 : (aw_full || (awvalid && awready));
    assign next_w_full = do_wr ? 1'b0 : (w_full || (wvalid && wready));
    assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
    assign w1c = (do_wr && wr_addr == IRQ_STATUS_ADDR) ? IRQ_W'(wr_data & wmask) : '0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            awready <= !next_aw_full;
            wready <= !next_w_full;
            if (awvalid && awready) wr_addr <= awaddr;
            if (wvalid && wready) begin
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            if (wr_addr == IRQ_STATUS_ADDR || wr_addr == IRQ_MASK_ADDR ||
                wr_addr == NEAR_EMPTY_OFS_ADDR || wr_addr == NEAR_FULL_OFS_ADDR) begin
                bresp <= RESP_OKAY;
            end else if (wr_addr == STATUS_ADDR || wr_addr == LEVEL_ADDR) begin
                bresp <= RESP_OKAY;
            end else begin
                bresp <= RESP_SLVERR;
            end
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= '0;
            ne_ofs <= OFS_RESET;
            nf_ofs <= OFS_RESET;
        end else if (do_wr) begin
            if (wr_addr == IRQ_MASK_ADDR) begin
                irq_mask <= IRQ_W'((wr_data & wmask) | (32'(irq_mask) & ~wmask));
            end else if (wr_addr == NEAR_EMPTY_OFS_ADDR) begin
                ne_ofs <= OFS_W'((wr_data & wmask) | (32'(ne_ofs) & ~wmask));
            end else if (wr_addr == NEAR_FULL_OFS_ADDR) begin
                nf_ofs <= OFS_W'((wr_data & wmask) | (32'(nf_ofs) & ~wmask));
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
            irq <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~w1c) | events;
            irq <= |(irq_status & irq_mask);
        end
    end

    // axi4-lite read side, one cycle to the answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            if (araddr == STATUS_ADDR) begin
                rdata <= {23'h0, state, near_full_flag, near_empty_flag, read_valid_flag,
                          write_space_flag, b_to_a_mail_flag, a_to_b_mail_flag};
            end else if (araddr == IRQ_STATUS_ADDR) begin
                rdata <= 32'(irq_status);
            end else if (araddr == IRQ_MASK_ADDR) begin
                rdata <= 32'(irq_mask);
            end else if (araddr == NEAR_EMPTY_OFS_ADDR) begin
                rdata <= 32'(ne_ofs);
            end else if (araddr == NEAR_FULL_OFS_ADDR) begin
                rdata <= 32'(nf_ofs);
            end else if (araddr == LEVEL_ADDR) begin
                rdata <= lvl32;
            end else begin
                rdata <= '0;
                rresp <= RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_flags: assert property (state == ST_RESET |=> !write_space_flag && !read_valid_flag
        && !near_empty_flag && near_full_flag && wr_ptr == '0)
        else $error("flags not forced during reset");
    a_reset_mail: assert property (state == ST_RESET |=> a_to_b_mail_flag && b_to_a_mail_flag)
        else $error("mail flags not high during reset");
    a_space_release: assert property ($rose(write_space_flag) |-> rel_cnt == IR_EDGES
        && $past(a_edge))
        else $error("write space rose too early");
    a_mail_set: assert property (a_mail_wr |=> !a_to_b_mail_flag ##1 a_to_b_mailbox
        == $past(a_in_s2, 2))
        else $error("a-to-b mail flag not set by write");
    a_mail_clear: assert property ($rose(a_to_b_mail_flag) |-> $past(b_edge || state != ST_RUN))
        else $error("a-to-b mail flag cleared off a port b edge");
    a_bus_b_mail: assert property (!b_sel_n && b_dir && b_mbs |=> port_b_bus_oe
        && port_b_bus_out == $past(a_to_b_mailbox))
        else $error("port b bus not showing mailbox");
    a_bus_a_drive: assert property (port_a_bus_oe |-> $past(!a_sel_n && !a_dir))
        else $error("port a bus driven in write direction");
    a_write_gate: assert property (!write_space_flag && state == ST_RUN |=> wr_ptr == $past(wr_ptr))
        else $error("fifo written without write space");
    a_read_gate: assert property (!read_valid_flag && state == ST_RUN |=> rd_ptr == $past(rd_ptr))
        else $error("fifo read without valid data");
endmodule : fifo_mailbox_ctrl
`default_nettype wire

// ==== testbench/port_agent.sv ====
// far-side port master: free-running port clock plus select, direction, enable and data
// assumes aclk is the design clock; controls move just after the port clock falls
`timescale 1ns/1ps
`default_nettype none
module port_agent #(
    parameter int HALF = 5
) (
    input wire logic aclk,
    output logic pclk,
    output logic sel_n,
    output logic dir,
    output logic mail,
    output logic en,
    output logic [35:0] data
);
    int cnt;

    initial begin
        cnt = 0;
        {sel_n, dir, mail, en} = 4'h8;
        data = 36'h0;
    end

    // port clocks run free; HALF of at least 5 keeps controls 5 aclk before the rise
    always @(posedge aclk) begin
        cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
    end
    assign pclk = (cnt < HALF);

    task automatic step;
        do @(posedge aclk); while (cnt != HALF - 1);
    endtask : step

    task automatic idle(input int n);
        repeat (n) step();
    endtask : idle

    // ctl is {select_n, dir, mail_sel, enable}; held across one whole rising edge
    task automatic op(input logic [3:0] ctl, input logic [35:0] v);
        step();
        {sel_n, dir, mail, en} <= ctl;
        data <= v;
        step();
        en <= 1'h0;
        // released data no longer shows the last word
        data <= ~v;
    endtask : op
endmodule : port_agent
`default_nettype wire

// ==== testbench/fifo_reset_and_mailbox_flags_tb.sv ====
// self-checking bench: fifo reset, flags, mailboxes, bus drive and registers
// assumes fifo_pkg and the design are compiled first; port_agent drives both ports
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: %s", $time, msg); end end
module fifo_reset_and_mailbox_flags_tb;
    import fifo_pkg::*;
    localparam logic [BUS_W-1:0] WORD = 36'h9_8765_4321;
    int errors = 0;
    int n_tests = 0;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, fifo_reset_n;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic port_a_clock, port_a_select_n, port_a_dir, port_a_mail_sel, port_a_strobe_en;
    logic port_b_clock, port_b_select_n, port_b_dir, port_b_mail_sel, port_b_xfer_en;
    logic [BUS_W-1:0] a_data, b_data, port_a_bus_out, port_b_bus_out;
    logic port_a_bus_oe, port_b_bus_oe, write_space_flag, read_valid_flag;
    logic near_empty_flag, near_full_flag, a_to_b_mail_flag, b_to_a_mail_flag;
    wire logic [BUS_W-1:0] port_a_bus_in = port_a_bus_oe ? port_a_bus_out : a_data;
    wire logic [BUS_W-1:0] port_b_bus_in = port_b_bus_oe ? port_b_bus_out : b_data;

    fifo_mailbox_ctrl uut (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .irq, .fifo_reset_n, .port_a_clock, .port_a_select_n, .port_a_dir,
        .port_a_mail_sel, .port_a_strobe_en, .port_a_bus_in, .port_a_bus_out, .port_a_bus_oe,
        .port_b_clock, .port_b_select_n, .port_b_dir, .port_b_mail_sel, .port_b_xfer_en,
        .port_b_bus_in, .port_b_bus_out, .port_b_bus_oe, .write_space_flag, .read_valid_flag,
        .near_empty_flag, .near_full_flag, .a_to_b_mail_flag, .b_to_a_mail_flag
    );
    // unequal half periods keep the two port clocks out of step
    port_agent #(.HALF(5)) pa (.aclk(aclk), .pclk(port_a_clock), .sel_n(port_a_select_n),
        .dir(port_a_dir), .mail(port_a_mail_sel), .en(port_a_strobe_en), .data(a_data));
    port_agent #(.HALF(7)) pb (.aclk(aclk), .pclk(port_b_clock), .sel_n(port_b_select_n),
        .dir(port_b_dir), .mail(port_b_mail_sel), .en(port_b_xfer_en), .data(b_data));

    always #12.5 aclk = ~aclk;

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'h0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'h0;
    endtask : axi_rd

    task automatic t_regs;
        axi_rd(IRQ_MASK_ADDR);
        `CHK(rd, 32'h0, "mask reset value")
        axi_rd(8'h40);
        `CHK(rs, RESP_SLVERR, "unmapped read")
        axi_wr(8'h40, 32'hffff_ffff);
        `CHK(rs, RESP_SLVERR, "unmapped write")
        pa.op(4'h5, WORD);
        pa.idle(2);
        axi_rd(LEVEL_ADDR);
        `CHK(rd, 32'h0, "write before any fifo reset")
        $display("t_regs done");
    endtask : t_regs

    task automatic t_short;
        fifo_reset_n <= 1'h0;
        repeat (18) @(posedge aclk);
        fifo_reset_n <= 1'h1;
        pb.idle(2);
        axi_rd(IRQ_STATUS_ADDR);
        `CHK(rd[EV_RST_SHORT], 1'h1, "short reset event")
        `CHK(write_space_flag, 1'h0, "no write space after short reset")
        $display("t_short done");
    endtask : t_short

    task automatic t_reset;
        fifo_reset_n <= 1'h0;
        pb.idle(2);
        `CHK({write_space_flag, read_valid_flag}, 2'h0, "ready flags in reset")
        `CHK({near_empty_flag, near_full_flag}, 2'h1, "near flags in reset")
        `CHK({a_to_b_mail_flag, b_to_a_mail_flag}, 2'h3, "mail flags in reset")
        pb.idle(4);
        fifo_reset_n <= 1'h1;
        pa.idle(1);
        `CHK(write_space_flag, 1'h0, "write space too early")
        pa.idle(5);
        `CHK(write_space_flag, 1'h1, "write space after reset")
        axi_rd(IRQ_STATUS_ADDR);
        `CHK(rd[3:0], 4'hc, "reset events")
        $display("t_reset done");
    endtask : t_reset

    task automatic t_irq;
        `CHK(irq, 1'h0, "masked event keeps irq low")
        axi_wr(IRQ_MASK_ADDR, 32'h4);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'h1, "unmasked event raises irq")
        axi_wr(IRQ_STATUS_ADDR, 32'hc);
        repeat (2) @(posedge aclk);
        `CHK(irq, 1'h0, "write one clears irq")
        axi_rd(IRQ_STATUS_ADDR);
        `CHK(rd[3:0], 4'h0, "status cleared")
        $display("t_irq done");
    endtask : t_irq

    task automatic t_fifo;
        // enable low: the first word must not be stored
        pa.op(4'h4, 36'h0_0000_00aa);
        pa.op(4'h5, WORD);
        pa.idle(1);
        axi_rd(LEVEL_ADDR);
        `CHK(rd, 32'h1, "one word stored")
        pb.idle(3);
        `CHK(read_valid_flag, 1'h1, "word ready at port b")
        pb.op(4'h5, 36'h0);
        `CHK(port_b_bus_out, WORD, "word on port b")
        `CHK(port_b_bus_oe, 1'h1, "port b driven when reading")
        $display("t_fifo done");
    endtask : t_fifo

    task automatic t_mail;
        pb.op(4'h6, 36'h0);
        pa.op(4'h7, 36'h5_a5a5_a5a5);
        repeat (3) @(posedge aclk);
        `CHK(a_to_b_mail_flag, 1'h0, "a-to-b mail flag set")
        `CHK(port_b_bus_out, 36'h5_a5a5_a5a5, "a-to-b mail on port b")
        pb.op(4'h7, 36'h0);
        repeat (3) @(posedge aclk);
        `CHK(a_to_b_mail_flag, 1'h1, "a-to-b mail taken")
        pb.op(4'h4, 36'h0);
        `CHK(port_b_bus_out, WORD, "port b back to fifo word")
        pa.op(4'h2, 36'h0);
        pb.op(4'h3, 36'h3_c3c3_c3c3);
        repeat (3) @(posedge aclk);
        `CHK(b_to_a_mail_flag, 1'h0, "b-to-a mail flag set")
        `CHK(port_a_bus_out, 36'h3_c3c3_c3c3, "b-to-a mail on port a")
        `CHK(port_a_bus_oe, 1'h1, "port a driven when reading")
        pa.op(4'h3, 36'h0);
        repeat (3) @(posedge aclk);
        `CHK(b_to_a_mail_flag, 1'h1, "b-to-a mail taken")
        axi_rd(IRQ_STATUS_ADDR);
        `CHK(rd[1:0], 2'h3, "mail events")
        $display("t_mail done");
    endtask : t_mail

    task automatic t_bus;
        pa.op(4'h8, 36'h0);
        pb.op(4'h0, 36'h0);
        `CHK({port_a_bus_oe, port_b_bus_oe}, 2'h0, "both buses released")
        $display("t_bus done");
    endtask : t_bus

    // byte lanes on a writable register, then a bus reset in mid-run
    task automatic t_restart;
        wstrb <= 4'h1;
        axi_wr(NEAR_EMPTY_OFS_ADDR, 32'h0000_5533);
        wstrb <= 4'hf;
        axi_rd(NEAR_EMPTY_OFS_ADDR);
        `CHK(rd, 32'h33, "byte lane write keeps upper lanes")
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        `CHK({a_to_b_mail_flag, b_to_a_mail_flag, irq}, 3'h6, "bus reset mail flags")
        `CHK({write_space_flag, near_full_flag}, 2'h1, "bus reset fifo flags")
        axi_rd(STATUS_ADDR);
        `CHK(rd, 32'h63, "uninit after bus reset")
        axi_rd(NEAR_EMPTY_OFS_ADDR);
        `CHK(rd, 32'(OFS_RESET), "offset back to reset value")
        $display("t_restart done");
    endtask : t_restart

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        aclk = 1'h0;
        aresetn = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        fifo_reset_n = 1'h1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_short();
        t_reset();
        t_irq();
        t_fifo();
        t_mail();
        t_bus();
        t_restart();
        complete_run();
    end

    // the whole sequence needs well under a thousand cycles; this limit only cuts a hang
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        complete_run();
    end
endmodule : fifo_reset_and_mailbox_flags_tb
`undef CHK
`default_nettype wire
